//--- rtl/dctg_timing_guard.v
// DDR2 device-side command timing guard: termination, calibration drive,
// mode-set termination update, and flags for controller spacing faults.
// Assumes commands are sampled on i_ref_clk and valid only with CKE high, except a REF with CKE falling (self-refresh entry).
`timescale 1ns/10ps
`include "dctg_consts.vh"

module dctg_timing_guard #(
   parameter REFRESH_CYCLE_PS = 100000,
   parameter PRECHARGE_PS = 15000
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_cke,
   input wire i_term_ctrl,
   input wire i_cmd_valid,
   input wire [2:0] i_cmd,
   input wire [2:0] i_bank,
   input wire i_autoprecharge,
   input wire i_wr_data_end,
   input wire [2:0] i_wr_bank,
   input wire i_wr_autoprecharge,
   input wire i_grade_800,
   input wire i_page_2k,
   input wire i_slow_exit,
   input wire [2:0] i_additive_latency,
   input wire i_mode_term_write,
   input wire [1:0] i_mode_term_value,
   input wire i_drive_cal_mode,
   output reg o_term_enable,
   output reg [1:0] o_term_value,
   output reg o_drive_cal,
   output reg [3:0] o_power_state,
   output reg [`DCTG_ERR_W-1:0] o_timing_error
);
   // ========================================================================
   // Cycle counts
   // ========================================================================
   localparam [31:0] FAW_1K_800 = `DCTG_CYC_UP(`DCTG_FAW_1K_800_PS);
   localparam [31:0] FAW_1K_667 = `DCTG_CYC_UP(`DCTG_FAW_1K_667_PS);
   localparam [31:0] FAW_2K_800 = `DCTG_CYC_UP(`DCTG_FAW_2K_800_PS);
   localparam [31:0] FAW_2K_667 = `DCTG_CYC_UP(`DCTG_FAW_2K_667_PS);
   localparam [31:0] RRD_1K = `DCTG_CYC_UP(`DCTG_RRD_1K_PS);
   localparam [31:0] RRD_2K = `DCTG_CYC_UP(`DCTG_RRD_2K_PS);
   localparam [31:0] WR_C = `DCTG_CYC_UP(`DCTG_WR_PS);
   localparam [31:0] RP_C = `DCTG_CYC_UP(PRECHARGE_PS);
   localparam [31:0] DAL_C = WR_C + RP_C;
   localparam [31:0] WTR_C = `DCTG_CYC_UP(`DCTG_WTR_PS);
   localparam [31:0] RTP_C = `DCTG_CYC_UP(`DCTG_RTP_PS);
   localparam [31:0] XSNR_C =
      `DCTG_CYC_UP(REFRESH_CYCLE_PS + `DCTG_XSNR_EXTRA_PS);

   // Power states, one-hot
   localparam [3:0] ST_ACTIVE = 4'h1;
   localparam [3:0] ST_PRE_PD = 4'h2;
   localparam [3:0] ST_ACT_PD = 4'h4;
   localparam [3:0] ST_SELF_REF = 4'h8;

   // Slow exit count minus additive latency, floored at one cycle
   function [7:0] sub_floor1;
      input [7:0] base;
      input [2:0] lat;
      reg [7:0] diff;
      begin
         diff = base - {5'h00, lat};
         sub_floor1 = (base > {5'h00, lat} + 8'h01) ? diff : 8'h01;
      end
   endfunction

   function [7:0] max8;
      input [7:0] a;
      input [7:0] b;
      begin
         max8 = (a > b) ? a : b;
      end
   endfunction

   // ========================================================================
   // Command decode
   // ========================================================================
   reg cke_q;
   reg term_ctrl_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [7:0] open_q;
   reg [1:0] faw_ptr_q;
   reg [2:0] term_sr_q;
   reg [`DCTG_ERR_W-1:0] err_d;

   wire cmd_ok = i_cmd_valid && i_cke;
   wire is_act = cmd_ok && (i_cmd == `DCTG_CMD_ACT);
   wire is_rd = cmd_ok && (i_cmd == `DCTG_CMD_RD);
   wire is_wr = cmd_ok && (i_cmd == `DCTG_CMD_WR);
   wire is_pre = cmd_ok && (i_cmd == `DCTG_CMD_PRE);
   wire is_mrs = cmd_ok && (i_cmd == `DCTG_CMD_MRS);
   wire is_any = cmd_ok && (i_cmd != `DCTG_CMD_NOP);
   wire cke_fall = cke_q && !i_cke;
   wire cke_rise = !cke_q && i_cke;
   wire sref_entry = cke_fall && i_cmd_valid && (i_cmd == `DCTG_CMD_REF);
   wire pd_entry = cke_fall && !sref_entry;

   // ========================================================================
   // Spacing timers
   // ========================================================================
   wire [3:0] faw_busy;
   wire [7:0] bank_busy;
   wire rrd_busy, ccd_busy, wtr_busy, exit_any_busy, exit_rd_busy;
   wire cke_busy, term_busy, mrd_busy, sync_term_busy;
   reg [7:0] faw_val, rrd_val, exit_any_val, exit_rd_val;
   reg exit_any_load, exit_rd_load;
   reg [7:0] bank_load;
   reg [7:0] bank_val [0:7];
   integer b;

   always @* begin
      if (i_page_2k) begin
         faw_val = i_grade_800 ? FAW_2K_800[7:0] : FAW_2K_667[7:0];
         rrd_val = RRD_2K[7:0];
      end else begin
         faw_val = i_grade_800 ? FAW_1K_800[7:0] : FAW_1K_667[7:0];
         rrd_val = RRD_1K[7:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : faw_slot
         // Slot reused every fourth activate: busy means a fifth came early
         dctg_gap_timer u_faw (
            .i_ref_clk(i_ref_clk),
            .i_rst_n(i_rst_n),
            .i_load(is_act && (faw_ptr_q == g)),
            .i_value(faw_val),
            .o_busy(faw_busy[g])
         );
      end
      for (g = 0; g < 8; g = g + 1) begin : bank_slot
         dctg_gap_timer u_bank (
            .i_ref_clk(i_ref_clk),
            .i_rst_n(i_rst_n),
            .i_load(bank_load[g]),
            .i_value(bank_val[g]),
            .o_busy(bank_busy[g])
         );
      end
   endgenerate

   // Write recovery, auto-precharge turnaround and read-to-precharge merge
   // into one hold-off per bank; the longest outstanding one wins.
   always @* begin
      for (b = 0; b < 8; b = b + 1) begin
         bank_load[b] = 1'b0;
         bank_val[b] = 8'h00;
         if (i_wr_data_end && (i_wr_bank == b)) begin
            bank_load[b] = 1'b1;
            bank_val[b] = i_wr_autoprecharge ? DAL_C[7:0] : WR_C[7:0];
         end
         if (is_rd && (i_bank == b)) begin
            bank_load[b] = 1'b1;
            bank_val[b] = max8(bank_val[b], RTP_C[7:0]);
         end
      end
   end

   // Exit hold-offs depend on which low-power state is left
   always @* begin
      exit_any_load = 1'b0;
      exit_rd_load = 1'b0;
      exit_any_val = 8'h00;
      exit_rd_val = 8'h00;
      if (cke_rise) begin
         case (state_q)
            ST_SELF_REF: begin
               exit_any_load = 1'b1;
               exit_any_val = XSNR_C[7:0];
               exit_rd_load = 1'b1;
               exit_rd_val = `DCTG_XSRD_CYC;
            end
            ST_PRE_PD: begin
               exit_any_load = 1'b1;
               exit_any_val = `DCTG_XP_CYC;
               exit_rd_load = 1'b1;
               exit_rd_val = `DCTG_XP_CYC;
            end
            ST_ACT_PD: begin
               exit_rd_load = 1'b1;
               if (!i_slow_exit) begin
                  exit_rd_val = `DCTG_XARD_CYC;
               end else if (i_grade_800) begin
                  exit_rd_val = sub_floor1(`DCTG_XARDS_800_CYC,
                                           i_additive_latency);
               end else begin
                  exit_rd_val = sub_floor1(`DCTG_XARDS_667_CYC,
                                           i_additive_latency);
               end
            end
            default: begin
               exit_rd_load = 1'b0;
            end
         endcase
      end
   end

   dctg_gap_timer u_rrd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(is_act), .i_value(rrd_val), .o_busy(rrd_busy));
   dctg_gap_timer u_ccd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(is_rd || is_wr), .i_value(`DCTG_CCD_CYC), .o_busy(ccd_busy));
   dctg_gap_timer u_wtr (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(i_wr_data_end), .i_value(WTR_C[7:0]), .o_busy(wtr_busy));
   dctg_gap_timer u_exit_any (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(exit_any_load), .i_value(exit_any_val),
      .o_busy(exit_any_busy));
   dctg_gap_timer u_exit_rd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(exit_rd_load), .i_value(exit_rd_val), .o_busy(exit_rd_busy));
   dctg_gap_timer u_cke (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(cke_fall || cke_rise), .i_value(`DCTG_CKE_CYC),
      .o_busy(cke_busy));
   dctg_gap_timer u_term (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(i_term_ctrl != term_ctrl_q), .i_value(`DCTG_ANPD_CYC),
      .o_busy(term_busy));
   dctg_gap_timer u_mrd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(is_mrs), .i_value(`DCTG_MRD_CYC), .o_busy(mrd_busy));
   dctg_gap_timer u_axpd (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_load(cke_rise && (state_q != ST_ACTIVE)),
      .i_value(`DCTG_AXPD_CYC), .o_busy(sync_term_busy));

   // ========================================================================
   // Fault detection
   // ========================================================================
   always @* begin
      err_d = {`DCTG_ERR_W{1'b0}};
      err_d[`DCTG_ERR_FAW] = is_act && faw_busy[faw_ptr_q];
      err_d[`DCTG_ERR_RRD] = is_act && rrd_busy;
      err_d[`DCTG_ERR_CCD] = (is_rd || is_wr) && ccd_busy;
      err_d[`DCTG_ERR_BANK] = (is_pre || is_act) && bank_busy[i_bank];
      err_d[`DCTG_ERR_WTR] = is_rd && wtr_busy;
      err_d[`DCTG_ERR_EXIT_ANY] = is_any && !is_rd && exit_any_busy;
      err_d[`DCTG_ERR_EXIT_RD] = is_rd && exit_rd_busy;
      err_d[`DCTG_ERR_CKE] = (cke_fall || cke_rise) && cke_busy;
      err_d[`DCTG_ERR_TERM_PD] = cke_fall && term_busy;
      err_d[`DCTG_ERR_MRD] = is_any && mrd_busy;
   end

   // ========================================================================
   // Power state
   // ========================================================================
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (sref_entry) begin
               state_d = ST_SELF_REF;
            end else if (pd_entry) begin
               // Open banks make it active power-down
               state_d = (open_q != 8'h00) ? ST_ACT_PD : ST_PRE_PD;
            end
         end
         ST_PRE_PD, ST_ACT_PD, ST_SELF_REF: begin
            if (cke_rise) begin
               state_d = ST_ACTIVE;
            end
         end
         default: begin
            state_d = ST_ACTIVE;
         end
      endcase
   end

   // ========================================================================
   // Registers and outputs
   // ========================================================================
   // Asynchronous path is kept through the exit window too, because the
   // synchronous two-cycle latency is not trustworthy until it ends.
   wire async_term = (state_q != ST_ACTIVE) || sync_term_busy;

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cke_q <= 1'b0;
         term_ctrl_q <= 1'b0;
         state_q <= ST_ACTIVE;
         open_q <= 8'h00;
         faw_ptr_q <= 2'h0;
         term_sr_q <= 3'h0;
         o_term_enable <= 1'b0;
         o_term_value <= 2'h0;
         o_drive_cal <= 1'b0;
         o_power_state <= ST_ACTIVE;
         o_timing_error <= {`DCTG_ERR_W{1'b0}};
      end else begin
         cke_q <= i_cke;
         term_ctrl_q <= i_term_ctrl;
         state_q <= state_d;
         o_power_state <= state_d;
         o_timing_error <= err_d;
         if (is_act) begin
            faw_ptr_q <= faw_ptr_q + 2'h1;
            open_q[i_bank] <= 1'b1;
         end else if (is_pre || ((is_rd || is_wr) && i_autoprecharge)) begin
            open_q[i_bank] <= 1'b0;
         end
         term_sr_q <= {term_sr_q[1:0], i_term_ctrl};
         if (async_term) begin
            // One cycle sits inside the 1.6 ns to 9.4 ns window
            o_term_enable <= i_term_ctrl;
         end else begin
            // Synchronous: on after 2 clocks, off after 3
            o_term_enable <= term_sr_q[1] | (o_term_enable & term_sr_q[2]);
         end
         if (is_mrs && i_mode_term_write) begin
            o_term_value <= i_mode_term_value;
         end
         o_drive_cal <= i_drive_cal_mode;
      end
   end
endmodule

//--- rtl/dctg_consts.vh
// Constants for the DDR2 command timing guard: clock, spacings, encodings.
// Assumes the device clock runs at 250 MHz; every ns figure is kept in ps.
`ifndef DCTG_CONSTS_VH
`define DCTG_CONSTS_VH

// ====================
// Clock and conversion
// ====================
`define DCTG_CLK_PS 4000
// Least times round up to whole cycles
`define DCTG_CYC_UP(ps) (((ps) + `DCTG_CLK_PS - 1) / `DCTG_CLK_PS)

// ====================
// Spacings given in time (ps)
// ====================
`define DCTG_FAW_1K_800_PS 35000
`define DCTG_FAW_1K_667_PS 37500
`define DCTG_FAW_2K_800_PS 45000
`define DCTG_FAW_2K_667_PS 50000
`define DCTG_RRD_1K_PS 7500
`define DCTG_RRD_2K_PS 10000
`define DCTG_WR_PS 15000
`define DCTG_WTR_PS 7500
`define DCTG_RTP_PS 7500
`define DCTG_XSNR_EXTRA_PS 10000
`define DCTG_OUT_ACCESS_MIN_PS (-400)
`define DCTG_OUT_ACCESS_MAX_PS 400
// Power-down termination window: least 1600 ps, longest 2 clocks + 1400 ps
`define DCTG_TERM_PD_MIN_PS (`DCTG_OUT_ACCESS_MIN_PS + 2000)
`define DCTG_TERM_PD_MAX_PS (2 * `DCTG_CLK_PS + `DCTG_OUT_ACCESS_MAX_PS + 1000)
`define DCTG_CAL_DRIVE_MAX_PS 12000
`define DCTG_MODE_TERM_MAX_PS 12000

// ====================
// Spacings given in clock cycles
// ====================
`define DCTG_CCD_CYC 8'h02
`define DCTG_XSRD_CYC 8'hc8
`define DCTG_XP_CYC 8'h02
`define DCTG_XARD_CYC 8'h02
`define DCTG_XARDS_800_CYC 8'h08
`define DCTG_XARDS_667_CYC 8'h07
`define DCTG_CKE_CYC 8'h03
`define DCTG_ANPD_CYC 8'h03
`define DCTG_AXPD_CYC 8'h08
`define DCTG_MRD_CYC 8'h02

// ====================
// Command encoding
// ====================
`define DCTG_CMD_NOP 3'h0
`define DCTG_CMD_ACT 3'h1
`define DCTG_CMD_RD 3'h2
`define DCTG_CMD_WR 3'h3
`define DCTG_CMD_PRE 3'h4
`define DCTG_CMD_REF 3'h5
`define DCTG_CMD_MRS 3'h6

// ====================
// Error vector bit positions
// ====================
`define DCTG_ERR_W 10
`define DCTG_ERR_FAW 0
`define DCTG_ERR_RRD 1
`define DCTG_ERR_CCD 2
`define DCTG_ERR_BANK 3
`define DCTG_ERR_WTR 4
`define DCTG_ERR_EXIT_ANY 5
`define DCTG_ERR_EXIT_RD 6
`define DCTG_ERR_CKE 7
`define DCTG_ERR_TERM_PD 8
`define DCTG_ERR_MRD 9

`endif

//--- rtl/dctg_gap_timer.v
// Down-counter that holds off a command class for a loaded number of cycles.
// Assumes loads come from the guard's own command decode, one clock domain.
`timescale 1ns/10ps
module dctg_gap_timer (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_load,
   input wire [7:0] i_value,
   output wire o_busy
);
   reg [7:0] cnt_q;
   reg [7:0] cnt_d;
   reg [7:0] dec;

   // ========================================================================
   // Counter
   // ========================================================================
   // Busy for value-1 edges, so a command N cycles on is legal; a new
   // load only extends the hold-off, a shorter one never cuts it
   always @* begin
      dec = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
      cnt_d = dec;
      if (i_load && (i_value > dec + 8'h01)) begin
         cnt_d = i_value - 8'h01;
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_busy = (cnt_q != 8'h00);
endmodule

//--- verification/dctg_guard_chk.sv
// Checker for the command timing guard: spacing flags and termination.
// Assumes it is bound to dctg_timing_guard and sees only that module's ports.
`timescale 1ns/10ps
`include "dctg_consts.vh"
module dctg_guard_chk (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_cke,
   input wire i_term_ctrl,
   input wire i_cmd_valid,
   input wire [2:0] i_cmd,
   input wire i_wr_data_end,
   input wire i_mode_term_write,
   input wire [1:0] i_mode_term_value,
   input wire i_drive_cal_mode,
   input wire o_term_enable,
   input wire [1:0] o_term_value,
   input wire o_drive_cal,
   input wire [`DCTG_ERR_W-1:0] o_timing_error
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   // =======================================================================
   // Command decode
   wire cmd_on = i_cmd_valid & i_cke;
   wire col_on = cmd_on & (i_cmd == `DCTG_CMD_RD | i_cmd == `DCTG_CMD_WR);
   wire act_on = cmd_on & (i_cmd == `DCTG_CMD_ACT);
   wire rd_on = cmd_on & (i_cmd == `DCTG_CMD_RD);
   wire mrs_on = cmd_on & (i_cmd == `DCTG_CMD_MRS);

   // =======================================================================
   // Sequences
   sequence s_pd;
      !i_cke [*4];
   endsequence
   // Twelve awake cycles put us past the exit window of synchronous timing
   sequence s_awake;
      i_cke [*8] ##1 i_cke [*4];
   endsequence
   sequence s_cke_glitch;
      $changed(i_cke) ##1 $changed(i_cke);
   endsequence

   // =======================================================================
   // Properties
   property p_ccd;
      col_on ##1 col_on |=> o_timing_error[`DCTG_ERR_CCD];
   endproperty
   property p_rrd;
      act_on ##1 act_on |=> o_timing_error[`DCTG_ERR_RRD];
   endproperty
   property p_mrd;
      mrs_on ##1 (cmd_on && i_cmd != `DCTG_CMD_NOP)
         |=> o_timing_error[`DCTG_ERR_MRD];
   endproperty
   property p_tval;
      mrs_on && i_mode_term_write |=> o_term_value == $past(i_mode_term_value);
   endproperty
   property p_wtr;
      i_wr_data_end ##1 rd_on |=> o_timing_error[`DCTG_ERR_WTR];
   endproperty
   property p_cke;
      s_cke_glitch |-> ##[1:2] o_timing_error[`DCTG_ERR_CKE];
   endproperty
   property p_cal;
      $rose(i_drive_cal_mode) |-> ##[1:3] o_drive_cal;
   endproperty
   property p_pd_on;
      s_pd ##0 $rose(i_term_ctrl) |=> o_term_enable;
   endproperty
   property p_pd_off;
      s_pd ##0 $fell(i_term_ctrl) |=> !o_term_enable;
   endproperty
   property p_sync;
      s_awake ##1 (i_cke && $rose(i_term_ctrl) && !o_term_enable)
         |=> !o_term_enable;
   endproperty

   a_ccd: assert property (p_ccd)
      else $error("column commands one cycle apart not flagged");
   a_rrd: assert property (p_rrd)
      else $error("back to back activates not flagged");
   a_mrd: assert property (p_mrd)
      else $error("command right after mode set not flagged");
   a_tval: assert property (p_tval)
      else $error("termination value not taken from mode set");
   a_wtr: assert property (p_wtr)
      else $error("read right after write data not flagged");
   a_cke: assert property (p_cke)
      else $error("short clock enable pulse not flagged");
   a_cal: assert property (p_cal)
      else $error("calibration drive late");
   a_pd_on: assert property (p_pd_on)
      else $error("termination not on in power-down");
   a_pd_off: assert property (p_pd_off)
      else $error("termination not off in power-down");
   a_sync: assert property (p_sync)
      else $error("termination on too early when awake");
endmodule

bind dctg_timing_guard dctg_guard_chk dctg_guard_chk_i (
   .i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n),
   .i_cke(i_cke),
   .i_term_ctrl(i_term_ctrl),
   .i_cmd_valid(i_cmd_valid),
   .i_cmd(i_cmd),
   .i_wr_data_end(i_wr_data_end),
   .i_mode_term_write(i_mode_term_write),
   .i_mode_term_value(i_mode_term_value),
   .i_drive_cal_mode(i_drive_cal_mode),
   .o_term_enable(o_term_enable),
   .o_term_value(o_term_value),
   .o_drive_cal(o_drive_cal),
   .o_timing_error(o_timing_error)
);

//--- verification/dctg_ctrl_model.sv
// Memory controller model: drives commands, clock enable and levels.
// Assumes the bench calls its tasks; every change but the mode-set termination value lands on a rising edge.
`timescale 1ns/10ps
`include "dctg_consts.vh"
module dctg_ctrl_model (
   input wire i_ref_clk,
   output reg o_cke,
   output reg o_term_ctrl,
   output reg o_cmd_valid,
   output reg [2:0] o_cmd,
   output reg [2:0] o_bank,
   output reg o_wr_data_end,
   output reg o_mode_term_write,
   output reg [1:0] o_mode_term_value,
   output reg o_page_2k,
   output reg o_slow_exit,
   output reg o_drive_cal_mode
);
   // =======================================================================
   // Start awake, slow exit chosen; the clock never stops here
   initial begin
      {o_cke, o_term_ctrl, o_cmd_valid, o_cmd, o_bank, o_wr_data_end,
       o_mode_term_write, o_mode_term_value, o_page_2k, o_slow_exit,
       o_drive_cal_mode} = 16'h8002;
   end

   // =======================================================================
   // Command bus; spacing faults are only made when the bench asks
   task st(input v, input [2:0] c, input [2:0] b, input w);
      begin
         @(posedge i_ref_clk);
         o_cmd_valid <= v;
         o_cmd <= c;
         o_bank <= b;
         o_wr_data_end <= w;
         o_mode_term_write <= v & (c == `DCTG_CMD_MRS);
      end
   endtask
   task nop(input integer n);
      repeat (n) st(1'b0, `DCTG_CMD_NOP, 3'h0, 1'b0);
   endtask
   task mode_register_set_command(input [1:0] tv);
      begin
         o_mode_term_value <= tv;
         st(1'b1, `DCTG_CMD_MRS, 3'h0, 1'b0);
      end
   endtask
   task cke(input k);
      begin
         nop(1);
         o_cke <= k;
      end
   endtask
   // Refresh with CKE falling at the same edge enters self-refresh
   task enter_sr;
      begin
         st(1'b1, `DCTG_CMD_REF, 3'h0, 1'b0);
         o_cke <= 1'b0;
      end
   endtask
   task lvl(input t, input d, input p);
      begin
         nop(1);
         o_term_ctrl <= t;
         o_drive_cal_mode <= d;
         o_page_2k <= p;
      end
   endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the command timing guard.
// Assumes a 250 MHz clock, 800 grade, additive latency 0, no auto-precharge.
`timescale 1ns/10ps
`include "dctg_consts.vh"
module testbench;
   reg i_ref_clk;
   reg i_rst_n = 1'b0;
   wire cke, term, vld, wde, mtw, page, slow, cal;
   wire [2:0] cmd, bank;
   wire [1:0] mtv;
   wire term_en, drive_cal;
   wire [1:0] term_val;
   wire [3:0] pstate;
   wire [`DCTG_ERR_W-1:0] err;
   integer fail_count = 0;
   integer n_checks = 0;
   integer v;

   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   dctg_ctrl_model dctg_ctrl_model_i (.i_ref_clk(i_ref_clk), .o_cke(cke),
      .o_term_ctrl(term), .o_cmd_valid(vld), .o_cmd(cmd), .o_bank(bank),
      .o_wr_data_end(wde), .o_mode_term_write(mtw), .o_mode_term_value(mtv),
      .o_page_2k(page), .o_slow_exit(slow), .o_drive_cal_mode(cal));

   dctg_timing_guard dctg_timing_guard_i (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .i_cke(cke), .i_term_ctrl(term), .i_cmd_valid(vld),
      .i_cmd(cmd), .i_bank(bank), .i_autoprecharge(1'b0),
      .i_wr_data_end(wde), .i_wr_bank(bank), .i_wr_autoprecharge(1'b0),
      .i_grade_800(1'b1), .i_page_2k(page), .i_slow_exit(slow),
      .i_additive_latency(3'h0), .i_mode_term_write(mtw),
      .i_mode_term_value(mtv), .i_drive_cal_mode(cal),
      .o_term_enable(term_en), .o_term_value(term_val),
      .o_drive_cal(drive_cal), .o_power_state(pstate),
      .o_timing_error(err));

   // =======================================================================
   // Checking and closing
   task check(input [7:0] seen, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Flags are one-cycle pulses, so watch three idle cycles for one
   task expect_err(input integer b, input e);
      reg seen;
      integer k;
      begin
         seen = 1'b0;
         for (k = 0; k < 3; k = k + 1) begin
            dctg_ctrl_model_i.nop(1);
            #1;
            seen = seen | err[b];
         end
         check({7'h0, seen}, {7'h0, e});
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // =======================================================================
   // Scenarios
   task t_cmd;
      begin
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h0, 1'b0);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h1, 1'b0);
         expect_err(`DCTG_ERR_CCD, 1'b1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_WR, 3'h0, 1'b0);
         dctg_ctrl_model_i.nop(1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h1, 1'b0);
         expect_err(`DCTG_ERR_CCD, 1'b0);
         for (v = 0; v < 4; v = v + 1) begin
            dctg_ctrl_model_i.mode_register_set_command(v[1:0]);
            dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h0, 1'b0);
            expect_err(`DCTG_ERR_MRD, 1'b1);
            check({6'h0, term_val}, v[7:0]);
         end
         dctg_ctrl_model_i.mode_register_set_command(2'h1);
         dctg_ctrl_model_i.nop(1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_PRE, 3'h0, 1'b0);
         expect_err(`DCTG_ERR_MRD, 1'b0);
         dctg_ctrl_model_i.lvl(1'b0, 1'b1, 1'b0);
         dctg_ctrl_model_i.nop(2);
         check({7'h0, drive_cal}, 8'h01);
         dctg_ctrl_model_i.lvl(1'b1, 1'b0, 1'b0);
         #1;
         check({7'h0, term_en}, 8'h00);
         dctg_ctrl_model_i.nop(3);
         #1;
         check({7'h0, term_en}, 8'h01);
         dctg_ctrl_model_i.lvl(1'b0, 1'b0, 1'b0);
         dctg_ctrl_model_i.nop(5);
         $display("t_cmd done");
      end
   endtask

   task t_pd;
      begin
         dctg_ctrl_model_i.cke(1'b0);
         dctg_ctrl_model_i.nop(2);
         #1;
         check({4'h0, pstate}, 8'h02);
         dctg_ctrl_model_i.lvl(1'b1, 1'b0, 1'b0);
         dctg_ctrl_model_i.nop(1);
         #1;
         check({7'h0, term_en}, 8'h01);
         dctg_ctrl_model_i.lvl(1'b0, 1'b0, 1'b0);
         dctg_ctrl_model_i.nop(1);
         #1;
         check({7'h0, term_en}, 8'h00);
         dctg_ctrl_model_i.cke(1'b1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h0, 1'b0);
         expect_err(`DCTG_ERR_EXIT_ANY, 1'b1);
         dctg_ctrl_model_i.nop(8);
         // Bank 0 is open now, so the next entry is active power-down
         dctg_ctrl_model_i.lvl(1'b1, 1'b0, 1'b0);
         dctg_ctrl_model_i.cke(1'b0);
         expect_err(`DCTG_ERR_TERM_PD, 1'b1);
         #1;
         check({4'h0, pstate}, 8'h04);
         dctg_ctrl_model_i.cke(1'b1);
         dctg_ctrl_model_i.nop(2);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h0, 1'b0);
         expect_err(`DCTG_ERR_EXIT_RD, 1'b1);
         dctg_ctrl_model_i.nop(10);
         dctg_ctrl_model_i.cke(1'b0);
         dctg_ctrl_model_i.cke(1'b1);
         expect_err(`DCTG_ERR_CKE, 1'b1);
         dctg_ctrl_model_i.nop(10);
         $display("t_pd done");
      end
   endtask

   task t_sr;
      begin
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_PRE, 3'h0, 1'b0);
         dctg_ctrl_model_i.nop(4);
         dctg_ctrl_model_i.enter_sr;
         dctg_ctrl_model_i.nop(3);
         #1;
         check({4'h0, pstate}, 8'h08);
         dctg_ctrl_model_i.cke(1'b1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h1, 1'b0);
         expect_err(`DCTG_ERR_EXIT_ANY, 1'b1);
         dctg_ctrl_model_i.nop(150);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h1, 1'b0);
         expect_err(`DCTG_ERR_EXIT_RD, 1'b1);
         dctg_ctrl_model_i.nop(50);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h1, 1'b0);
         expect_err(`DCTG_ERR_EXIT_RD, 1'b0);
         $display("t_sr done");
      end
   endtask

   task t_act;
      begin
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h2, 1'b0);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h3, 1'b0);
         expect_err(`DCTG_ERR_RRD, 1'b1);
         dctg_ctrl_model_i.lvl(1'b0, 1'b0, 1'b1);
         dctg_ctrl_model_i.nop(15);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h4, 1'b0);
         dctg_ctrl_model_i.nop(1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, 3'h5, 1'b0);
         expect_err(`DCTG_ERR_RRD, 1'b1);
         dctg_ctrl_model_i.lvl(1'b0, 1'b0, 1'b0);
         dctg_ctrl_model_i.nop(15);
         for (v = 0; v < 5; v = v + 1) begin
            dctg_ctrl_model_i.nop(1);
            dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_ACT, v[2:0], 1'b0);
         end
         expect_err(`DCTG_ERR_FAW, 1'b1);
         dctg_ctrl_model_i.st(1'b0, `DCTG_CMD_NOP, 3'h3, 1'b1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_RD, 3'h3, 1'b0);
         expect_err(`DCTG_ERR_WTR, 1'b1);
         dctg_ctrl_model_i.st(1'b0, `DCTG_CMD_NOP, 3'h3, 1'b1);
         dctg_ctrl_model_i.nop(1);
         dctg_ctrl_model_i.st(1'b1, `DCTG_CMD_PRE, 3'h3, 1'b0);
         expect_err(`DCTG_ERR_BANK, 1'b1);
         $display("t_act done");
      end
   endtask

   // =======================================================================
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      dctg_ctrl_model_i.nop(14);
      t_cmd;
      t_pd;
      t_sr;
      t_act;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      fail_count = fail_count + 1;
      stop_test;
   end
endmodule
